// ==== hdl/intrusion_filter.sv ====
// one tamper input detector: edge mode or filtered level mode.
// assumes the pin is already synchronised and a one-cycle sample strobe.
`timescale 1ns/1ps
`default_nettype none

module intrusion_filter (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // synchronised pin and sample strobe
    input  wire logic       pin,
    input  wire logic       sample,
    // configuration
    input  wire logic       enable,
    input  wire logic       polarity,
    input  wire logic [1:0] filter_count,
    // detection pulse
    output logic            detect
);

    typedef struct packed {
        logic       prev;
        logic [3:0] run;
        logic       done;
        logic       det;
    } filt_t;

    filt_t s_q;
    filt_t s_d;
    logic  active;
    logic  [3:0] need;

    // ------------------------------------------------------------------
    // detection criterion
    // ------------------------------------------------------------------
    // level mode needs 2, 4 or 8 consecutive active samples
    always_comb begin
        s_d    = s_q;
        s_d.det  = 1'b0;
        s_d.prev = pin;
        active = (pin == polarity);
        need   = 4'(4'h1 << filter_count);
        if (!enable) begin
            s_d.run  = 4'h0;
            s_d.done = 1'b0;
        end else if (filter_count == 2'h0) begin
            // polarity low picks rising, high picks falling
            s_d.det = polarity ? (s_q.prev & ~pin) : (~s_q.prev & pin);
        end else if (sample) begin
            if (!active) begin
                s_d.run  = 4'h0;
                s_d.done = 1'b0;
            end else if (!s_q.done) begin
                s_d.run = s_q.run + 4'h1;
                if (s_q.run + 4'h1 == need) begin
                    s_d.det  = 1'b1;
                    s_d.done = 1'b1;                     // one event per active stretch
                end
            end
        end
        if (!rstn) begin
            s_d = '0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign detect = s_q.det;

endmodule

`default_nettype wire

// ==== hdl/rtc_ext.sv ====
// calendar-clock extension: timestamp capture, smooth calibration,
// tamper detection with precharge, alarm sub-second match, backup words.
// assumes CLK is the calendar clock, RSTN the backup-domain reset, and
// that prescaler count, weekday and alarm field matches come from the
// calendar core on the same clock.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module rtc_ext #(
    parameter int SAMPLE_SHIFT_MAX = rtc_ext_pkg::SAMPLE_SHIFT_MAX
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // calendar core
    input  wire logic [15:0] PRESCALER_COUNT,
    input  wire logic [2:0]  WEEKDAY_NOW,
    input  wire logic        SECOND_TICK,
    input  wire logic        STAMP_ENABLE,
    input  wire logic        ALARM_A_ON,
    input  wire logic        ALARM_B_ON,
    input  wire logic        FIELDS_MATCH_A,
    input  wire logic        FIELDS_MATCH_B,
    input  wire logic        READPROT_OFF,
    // flag clears from the status register
    input  wire logic        STAMP_FLAG_CLR,
    input  wire logic        INTRUSION_ONE_CLR,
    input  wire logic        INTRUSION_TWO_CLR,
    // pins
    input  wire logic        ALT_PIN_ONE,
    input  wire logic        ALT_PIN_TWO,
    input  wire logic        INTRUSION_IN_TWO,
    output logic             PULLUP_EN,
    // status and events
    output logic             STAMP_CAPTURED_FLAG,
    output logic             INTRUSION_ONE_FLAG,
    output logic             INTRUSION_TWO_FLAG,
    output logic             INTRUSION_IRQ,
    output logic             ALARM_A_HIT,
    output logic             ALARM_B_HIT,
    output logic             ALARM_PIN_DRIVE_TYPE,
    // calibration pulse control
    output logic             CAL_MASK_PULSE,
    output logic             CAL_INSERT_PULSE
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                  cal;
        logic [18:0]                  tcfg;
        logic [31:0]                  alarm_a;
        logic [31:0]                  alarm_b;
        logic [2:0]                   stamp_day;
        logic [15:0]                  stamp_sub;
        logic                         stamp_flag;
        logic                         tflag_one;
        logic                         tflag_two;
        logic [19:0]                  win_cnt;
        logic                         mask_pulse;
        logic                         insert_pulse;
        logic [15:0]                  samp_cnt;
        logic [3:0]                   pre_cnt;
        rtc_ext_pkg::sample_phase_t   phase;
        logic                         sample_go;
        logic [2:0]                   pin_s1;
        logic [2:0]                   pin_s2;
        logic                         stamp_prev;
        logic                         hit_a_lvl;
        logic                         hit_b_lvl;
        logic                         hit_a;
        logic                         hit_b;
        logic [31:0]                  rdata;
        logic [19:0][31:0]            backup;
    } state_t;

    state_t      s_q;
    state_t      s_d;
    logic [1:0]  tpin;
    logic [1:0]  tdet;
    logic [1:0]  ten;
    logic [1:0]  tpol;
    logic        det_any;
    logic        stamp_pin;
    logic        stamp_evt;
    logic [8:0]  reduce;
    logic [8:0]  slot;
    logic [8:0]  slot_limit;
    logic [3:0]  shift;
    logic [15:0] samp_period;
    logic        now_a;
    logic        now_b;
    logic        bk_hit;
    logic [4:0]  bk_idx;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // sub-second compare on the low mask-width bits, never bit 15
    function automatic logic frac_match(input logic [31:0] areg,
                                        input logic [15:0] cnt);
        logic [3:0]  width;
        logic [14:0] msk;
        width = areg[rtc_ext_pkg::AS_MASK_LSB +: 4];
        msk   = (width >= 4'hf) ? 15'h7fff : 15'((16'h1 << width) - 16'h1);
        frac_match = ((areg[14:0] ^ cnt[14:0]) & msk) == 15'h0;
    endfunction

    // a cycle-bit write clears the low reduce bits it forbids
    function automatic logic [15:0] cal_store(input logic [31:0] w);
        logic [15:0] v;
        v = w[15:0];
        v[12:9] = 4'h0;
        if (w[rtc_ext_pkg::CAL_SIXTEEN_BIT]) begin
            v[0] = 1'b0;
        end
        if (w[rtc_ext_pkg::CAL_EIGHT_BIT]) begin
            v[1:0] = 2'h0;
        end
        cal_store = v;
    endfunction

    // ------------------------------------------------------------------
    // tamper detectors, one per input
    // ------------------------------------------------------------------
    // pin map: tamper one from either alternate pin, tamper two fixed
    assign tpin[0] = s_q.tcfg[rtc_ext_pkg::TC_ONE_MAP_BIT] ? s_q.pin_s2[1]
                                                           : s_q.pin_s2[0];
    assign tpin[1] = s_q.pin_s2[2];
    assign ten[0]  = s_q.tcfg[rtc_ext_pkg::TC_ONE_EN_BIT];
    assign ten[1]  = s_q.tcfg[rtc_ext_pkg::TC_TWO_EN_BIT];
    assign tpol[0] = s_q.tcfg[rtc_ext_pkg::TC_ONE_POL_BIT];
    assign tpol[1] = s_q.tcfg[rtc_ext_pkg::TC_TWO_POL_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tamper
            intrusion_filter u_filt (
                .clk          (CLK),
                .rstn         (RSTN),
                .pin          (tpin[gi]),
                .sample       (s_q.sample_go),
                .enable       (ten[gi]),
                .polarity     (tpol[gi]),
                .filter_count (s_q.tcfg[rtc_ext_pkg::TC_FILT_LSB +: 2]),
                .detect       (tdet[gi])
            );
        end
    endgenerate
    assign det_any = |tdet;
    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // two-flop synchronisers for the three pins
        s_d.pin_s1 = {INTRUSION_IN_TWO, ALT_PIN_TWO, ALT_PIN_ONE};
        s_d.pin_s2 = s_q.pin_s1;
        // smooth calibration: 512 slots of 2^11 pulses per 32 s window
        s_d.win_cnt = s_q.win_cnt + 20'h1;               // wraps at 2^20
        reduce = s_q.cal[rtc_ext_pkg::CAL_REDUCE_MSB:0];
        if (s_q.cal[rtc_ext_pkg::CAL_EIGHT_BIT]) begin
            slot       = {2'h0, s_q.win_cnt[17:11]};     // 8 s cycle
            slot_limit = {2'h0, reduce[8:2]};
        end else if (s_q.cal[rtc_ext_pkg::CAL_SIXTEEN_BIT]) begin
            slot       = {1'b0, s_q.win_cnt[18:11]};     // 16 s cycle
            slot_limit = {1'b0, reduce[8:1]};
        end else begin
            slot       = s_q.win_cnt[19:11];
            slot_limit = reduce;
        end
        // masked pulses sit mid-slot so they never meet an inserted one
        s_d.mask_pulse = (s_q.win_cnt[10:0] == rtc_ext_pkg::CAL_MASK_SLOT)
                         && (slot < slot_limit);
        s_d.insert_pulse = (s_q.win_cnt[10:0] == 11'h000)
                           && s_q.cal[rtc_ext_pkg::CAL_INSERT_BIT];
        // tamper sampling rate: divide by 2^(max - code)
        shift = 4'(SAMPLE_SHIFT_MAX);
        if (4'(s_q.tcfg[rtc_ext_pkg::TC_SAMP_LSB +: 3]) < shift) begin
            shift = shift - 4'(s_q.tcfg[rtc_ext_pkg::TC_SAMP_LSB +: 3]);
        end else begin
            shift = 4'h0;
        end
        samp_period = 16'((17'h1 << shift) - 17'h1);
        s_d.sample_go = 1'b0;
        case (s_q.phase)
            rtc_ext_pkg::PH_WAIT: begin
                if (s_q.samp_cnt >= samp_period) begin
                    s_d.samp_cnt = 16'h0;
                    // precharge lasts 1, 2, 4 or 8 pulses
                    s_d.pre_cnt  = 4'((5'h1 << s_q.tcfg[rtc_ext_pkg::TC_PRE_LSB +: 2]) - 5'h1);
                    s_d.phase    = rtc_ext_pkg::PH_CHARGE;
                end else begin
                    s_d.samp_cnt = s_q.samp_cnt + 16'h1;
                end
            end
            rtc_ext_pkg::PH_CHARGE: begin
                if (s_q.pre_cnt == 4'h0) begin
                    s_d.sample_go = 1'b1;                // sample right after charging
                    s_d.phase     = rtc_ext_pkg::PH_WAIT;
                end else begin
                    s_d.pre_cnt = s_q.pre_cnt - 4'h1;
                end
            end
            default: begin
                s_d.phase = rtc_ext_pkg::PH_WAIT;
            end
        endcase
        // tamper flags: a detection beats a clear in the same cycle
        if (tdet[0]) begin
            s_d.tflag_one = 1'b1;
        end else if (INTRUSION_ONE_CLR) begin
            s_d.tflag_one = 1'b0;
        end
        if (tdet[1]) begin
            s_d.tflag_two = 1'b1;
        end else if (INTRUSION_TWO_CLR) begin
            s_d.tflag_two = 1'b0;
        end
        // timestamp: pin edge when enabled, or any tamper with stamp bit
        stamp_pin = s_q.tcfg[rtc_ext_pkg::TC_STAMP_MAP_BIT] ? s_q.pin_s2[1]
                                                            : s_q.pin_s2[0];
        s_d.stamp_prev = stamp_pin;
        stamp_evt = (STAMP_ENABLE && stamp_pin && !s_q.stamp_prev)
                    || (det_any && s_q.tcfg[rtc_ext_pkg::TC_STAMP_EN_BIT]);
        if (stamp_evt) begin
            s_d.stamp_flag = 1'b1;
            s_d.stamp_day  = WEEKDAY_NOW;
            s_d.stamp_sub  = PRESCALER_COUNT;
        end else if (STAMP_FLAG_CLR) begin
            s_d.stamp_flag = 1'b0;
            s_d.stamp_day  = 3'h0;
            s_d.stamp_sub  = 16'h0;
        end
        // alarm sub-second match, one pulse on entering the match
        now_a = ALARM_A_ON && FIELDS_MATCH_A &&
                ((s_q.alarm_a[rtc_ext_pkg::AS_MASK_LSB +: 4] == 4'h0) ? SECOND_TICK
                 : frac_match(s_q.alarm_a, PRESCALER_COUNT));
        now_b = ALARM_B_ON && FIELDS_MATCH_B &&
                ((s_q.alarm_b[rtc_ext_pkg::AS_MASK_LSB +: 4] == 4'h0) ? SECOND_TICK
                 : frac_match(s_q.alarm_b, PRESCALER_COUNT));
        s_d.hit_a_lvl = now_a;
        s_d.hit_b_lvl = now_b;
        s_d.hit_a     = now_a && !s_q.hit_a_lvl;
        s_d.hit_b     = now_b && !s_q.hit_b_lvl;
        // register writes; write gating of alarm regs is left to software
        bk_hit = (ADDR >= rtc_ext_pkg::OFS_BACKUP_FIRST) &&
                 (ADDR <= rtc_ext_pkg::OFS_BACKUP_LAST) && (ADDR[1:0] == 2'h0);
        bk_idx = 5'((ADDR - rtc_ext_pkg::OFS_BACKUP_FIRST) >> 2);
        if (WR) begin
            case (ADDR)
                rtc_ext_pkg::OFS_SMOOTH_CAL: begin
                    s_d.cal = cal_store(WDATA);
                end
                rtc_ext_pkg::OFS_TAMPER_CFG: begin
                    s_d.tcfg = WDATA[rtc_ext_pkg::TC_USED_BITS-1:0] & 19'h7ff9f;
                end
                rtc_ext_pkg::OFS_ALARM_A_FRACTION_SECOND_VALUE: begin
                    s_d.alarm_a = WDATA & 32'h0f00_7fff;
                end
                rtc_ext_pkg::OFS_ALARM_B_FRACTION_SECOND_VALUE: begin
                    s_d.alarm_b = WDATA & 32'h0f00_7fff;
                end
                default: begin
                    if (bk_hit) begin
                        s_d.backup[bk_idx] = WDATA;
                    end
                end
            endcase
        end
        // wipe wins over any write and holds while tamper one is flagged
        if (det_any || READPROT_OFF || s_q.tflag_one) begin
            s_d.backup = '0;
        end
        // read data stands in the cycle after the strobe only
        s_d.rdata = rtc_ext_pkg::RST_ZERO_WORD;
        if (RD) begin
            case (ADDR)
                rtc_ext_pkg::OFS_STAMP_DATE: begin
                    s_d.rdata[rtc_ext_pkg::WEEKDAY_LSB +: 3] = s_q.stamp_day;
                end
                rtc_ext_pkg::OFS_STAMP_FRACTION_SECOND_VALUE: begin
                    s_d.rdata[15:0] = s_q.stamp_sub;
                end
                rtc_ext_pkg::OFS_SMOOTH_CAL: begin
                    s_d.rdata[15:0] = s_q.cal;
                end
                rtc_ext_pkg::OFS_TAMPER_CFG: begin
                    s_d.rdata[18:0] = s_q.tcfg;
                end
                rtc_ext_pkg::OFS_ALARM_A_FRACTION_SECOND_VALUE: begin
                    s_d.rdata = s_q.alarm_a;
                end
                rtc_ext_pkg::OFS_ALARM_B_FRACTION_SECOND_VALUE: begin
                    s_d.rdata = s_q.alarm_b;
                end
                default: begin
                    if (bk_hit) begin
                        s_d.rdata = s_q.backup[bk_idx];
                    end
                end
            endcase
        end
        // backup-domain reset clears everything but the phase (to PH_WAIT), backup words included
        if (!RSTN) begin
            s_d       = '0;
            s_d.phase = rtc_ext_pkg::PH_WAIT;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RDATA                = s_q.rdata;
    assign STAMP_CAPTURED_FLAG  = s_q.stamp_flag;
    assign INTRUSION_ONE_FLAG   = s_q.tflag_one;
    assign INTRUSION_TWO_FLAG   = s_q.tflag_two;
    assign INTRUSION_IRQ        = s_q.tcfg[rtc_ext_pkg::TC_IRQ_EN_BIT]
                                  && (s_q.tflag_one || s_q.tflag_two);
    assign ALARM_A_HIT          = s_q.hit_a;
    assign ALARM_B_HIT          = s_q.hit_b;
    assign ALARM_PIN_DRIVE_TYPE = s_q.tcfg[rtc_ext_pkg::TC_ALARM_PP_BIT];
    assign CAL_MASK_PULSE       = s_q.mask_pulse;
    assign CAL_INSERT_PULSE     = s_q.insert_pulse;
    // pull-up only while charging, never when disabled by software
    assign PULLUP_EN            = (s_q.phase == rtc_ext_pkg::PH_CHARGE)
                                  && !s_q.tcfg[rtc_ext_pkg::TC_PULL_OFF_BIT];

endmodule

`default_nettype wire

// ==== pkg/rtc_ext_pkg.sv ====
// package of constants for the calendar-clock extension block:
// register offsets, field positions, reset values and counts.
// assumes a 32-bit register port with byte offsets on an 8-bit address.
package rtc_ext_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_STAMP_DATE     = 8'h34;
    localparam logic [7:0] OFS_STAMP_FRACTION_SECOND_VALUE   = 8'h38;
    localparam logic [7:0] OFS_SMOOTH_CAL     = 8'h3c;
    localparam logic [7:0] OFS_TAMPER_CFG     = 8'h40;
    localparam logic [7:0] OFS_ALARM_A_FRACTION_SECOND_VALUE = 8'h44;
    localparam logic [7:0] OFS_ALARM_B_FRACTION_SECOND_VALUE = 8'h48;
    localparam logic [7:0] OFS_BACKUP_FIRST   = 8'h50;
    localparam logic [7:0] OFS_BACKUP_LAST    = 8'h9c;
    localparam int         NUM_BACKUP         = 20;

    // ------------------------------------------------------------------
    // reset values (backup-domain reset)
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int WEEKDAY_LSB      = 13;  // stamp date 15:13
    localparam int CAL_REDUCE_MSB   = 8;   // smooth cal 8:0
    localparam int CAL_SIXTEEN_BIT  = 13;
    localparam int CAL_EIGHT_BIT    = 14;
    localparam int CAL_INSERT_BIT   = 15;
    localparam int TC_ONE_EN_BIT    = 0;
    localparam int TC_ONE_POL_BIT   = 1;
    localparam int TC_IRQ_EN_BIT    = 2;
    localparam int TC_TWO_EN_BIT    = 3;
    localparam int TC_TWO_POL_BIT   = 4;
    localparam int TC_STAMP_EN_BIT  = 7;
    localparam int TC_SAMP_LSB      = 8;   // 10:8
    localparam int TC_FILT_LSB      = 11;  // 12:11
    localparam int TC_PRE_LSB       = 13;  // 14:13
    localparam int TC_PULL_OFF_BIT  = 15;
    localparam int TC_ONE_MAP_BIT   = 16;
    localparam int TC_STAMP_MAP_BIT = 17;
    localparam int TC_ALARM_PP_BIT  = 18;
    localparam int TC_USED_BITS     = 19;
    localparam int AS_VALUE_BITS    = 15;  // alarm fraction_second_value 14:0
    localparam int AS_MASK_LSB      = 24;  // 27:24

    // ------------------------------------------------------------------
    // timing counts, in calendar clock pulses
    // ------------------------------------------------------------------
    localparam int          CAL_WINDOW_BITS = 20;  // 32 s window
    localparam int          CAL_INSERT_BITS = 11;  // one extra pulse per 2^11
    localparam logic [10:0] CAL_MASK_SLOT   = 11'h400; // mid-slot, apart from insert
    localparam int          SAMPLE_SHIFT_MAX = 15; // slowest tamper sample rate

    // ------------------------------------------------------------------
    // tamper sampling phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_WAIT   = 2'b01,
        PH_CHARGE = 2'b10
    } sample_phase_t;

endpackage

// ==== tb/rtc_ext_properties.sv ====
// checker: pulse and flag relations at the block's ports.
// assumes a bind into rtc_ext on its one calendar clock.
`timescale 1ns/1ps
`default_nettype none
module rtc_ext_checks (
    // watched ports, grouped to keep the file short
    input wire logic CLK, RSTN, INTRUSION_IRQ, INTRUSION_ONE_FLAG, INTRUSION_TWO_FLAG,
    input wire logic INTRUSION_ONE_CLR, CAL_MASK_PULSE, CAL_INSERT_PULSE,
    input wire logic ALARM_A_HIT, ALARM_A_ON, FIELDS_MATCH_A,
    input wire logic ALARM_B_HIT, ALARM_B_ON, FIELDS_MATCH_B
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // interrupt, calibration, alarm and flag relations
    a_irq_has_flag: assert property (
        INTRUSION_IRQ |-> (INTRUSION_ONE_FLAG || INTRUSION_TWO_FLAG)) else $error("irq");
    a_insert_gap: assert property (
        CAL_INSERT_PULSE |=> !CAL_INSERT_PULSE [*8]) else $error("insert gap");
    a_mask_gap: assert property (
        CAL_MASK_PULSE |=> !CAL_MASK_PULSE [*8]) else $error("mask gap");
    a_pulses_apart: assert property (
        !(CAL_MASK_PULSE && CAL_INSERT_PULSE)) else $error("mask with insert");
    a_hit_a_cause: assert property (
        ALARM_A_HIT |-> $past(ALARM_A_ON && FIELDS_MATCH_A)) else $error("hit a");
    a_hit_a_once: assert property (
        ALARM_A_HIT |=> !ALARM_A_HIT) else $error("hit a long");
    a_hit_b_cause: assert property (
        ALARM_B_HIT |-> $past(ALARM_B_ON && FIELDS_MATCH_B)) else $error("hit b");
    a_flag_sticky: assert property (
        INTRUSION_ONE_FLAG && !INTRUSION_ONE_CLR |=> INTRUSION_ONE_FLAG) else $error("flag");
endmodule
`default_nettype wire

// ==== tb/tamper_pins.sv ====
// partner: external alternate pins and tamper pin two.
// assumes the bench sets wanted levels in drv.
`timescale 1ns/1ps
`default_nettype none
module tamper_pins (
    input  wire logic       clk,
    input  wire logic [2:0] drv,
    output logic            pin_one,
    output logic            pin_two,
    output logic            pin_tp2
);
    // levels move just after the edge, as a real source would
    always_ff @(posedge clk) begin
        {pin_tp2, pin_two, pin_one} <= drv;
    end
endmodule
`default_nettype wire

// ==== tb/test_rtc_ext.sv ====
// bench: registers, insert pulse, tamper stamp, alarm match.
// assumes the pin model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_rtc_ext;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, on = 0, fm = 0, tick = 0, sclr = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [2:0] drv = 0;
    logic pin1, pin2, pin3, sf, f1, f2, pu, msk, irq, hita, hitb, ins;
    wire [6:0] ev = {f2, pu, msk, hita, hitb, f1, ins};
    int fails = 0, check_count = 0, n;
    always #12.5 clk = ~clk;
    tamper_pins u_tamper_pins (.clk(clk), .drv(drv), .pin_one(pin1), .pin_two(pin2),
        .pin_tp2(pin3));
    rtc_ext #(.SAMPLE_SHIFT_MAX(3)) u_rtc_ext (.CLK(clk), .RSTN(rstn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PRESCALER_COUNT(16'h1235),
        .WEEKDAY_NOW(3'h7), .SECOND_TICK(tick), .STAMP_ENABLE(1'b0), .ALARM_A_ON(on),
        .ALARM_B_ON(on), .FIELDS_MATCH_A(fm), .FIELDS_MATCH_B(fm), .READPROT_OFF(1'b0),
        .STAMP_FLAG_CLR(sclr), .INTRUSION_ONE_CLR(sclr), .INTRUSION_TWO_CLR(sclr),
        .ALT_PIN_ONE(pin1), .ALT_PIN_TWO(pin2), .INTRUSION_IN_TWO(pin3), .PULLUP_EN(pu),
        .STAMP_CAPTURED_FLAG(sf), .INTRUSION_ONE_FLAG(f1), .INTRUSION_TWO_FLAG(f2),
        .INTRUSION_IRQ(irq), .ALARM_A_HIT(hita), .ALARM_B_HIT(hitb),
        .ALARM_PIN_DRIVE_TYPE(), .CAL_MASK_PULSE(msk), .CAL_INSERT_PULSE(ins));
    // compare, bus cycles and bounded wait
    task chk(string s, logic [31:0] g, logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task wrr(logic [7:0] a, logic [31:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 0;
    endtask
    task rdc(logic [7:0] a, logic [31:0] e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 0;
        @(negedge clk) chk("rdata", rdata, e);
    endtask
    task wt(int b);
        n = 0;
        do begin @(negedge clk); n++; end while (!ev[b] && n < 3000);
        if (n == 3000) begin fails++; end_of_test(); end
    endtask
    task t_regs;
        wrr(8'h3c, 32'h2003); // one cycle bit at a time
        rdc(8'h3c, 32'h2002);
        wrr(8'h3c, 32'h4003);
        rdc(8'h3c, 32'h4000);
        wrr(8'h50, 32'ha5a5_a5a5);
        rdc(8'h50, 32'ha5a5_a5a5);
        rdc(8'h4c, 32'h0);
    endtask
    task t_cal;
        wrr(8'h3c, 32'h8005); // insert on, mask five pulses per window
        wt(0);
        wt(0);
        chk("insert gap", n, 2048);
        wt(4);
        chk("mask offset", n, 1024);
    endtask
    task t_tamper;
        wrr(8'h40, 32'h85); // edge mode, rising
        @(posedge clk) drv <= 3'h1;
        wt(1);
        @(negedge clk);
        chk("irq", irq, 1);
        chk("stamp flag", sf, 1);
        rdc(8'h38, 32'h1235);
        rdc(8'h34, 32'he000);
        rdc(8'h50, 32'h0);
        @(posedge clk) sclr <= 1;
        @(posedge clk) sclr <= 0;
        rdc(8'h38, 32'h0);
    endtask
    task t_alarm;
        wrr(8'h44, 32'h0100_0001); // written while alarms are off
        @(posedge clk) {on, fm} <= 2'b11;
        wt(3);
        chk("hit b idle", hitb, 0);
        @(posedge clk) tick <= 1;
        @(posedge clk) tick <= 0;
        wt(2);
        chk("hit b", hitb, 1);
    endtask
    task t_level;
        int k;
        wrr(8'h40, 32'h2818); // pin two level high, two samples, 2-cycle charge
        // skip a charge that may have started under the old setting
        repeat (2) begin
            k = 0;
            wt(5);
            while (pu && k < 9) begin @(negedge clk); k++; end
        end
        chk("precharge", k, 2);
        @(posedge clk) drv <= 3'h5;
        wt(6);
        chk("irq off", irq, 0);
        wrr(8'h40, 32'ha818);
        k = 0;
        repeat (30) begin @(negedge clk); k += pu; end
        chk("pullup off", k, 0);
    endtask
    task end_of_test;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        t_regs();
        t_cal();
        t_tamper();
        t_alarm();
        t_level();
        end_of_test();
    end
endmodule
bind rtc_ext rtc_ext_checks u_rtc_ext_checks (.*);
`default_nettype wire
